// ### design/nvs_sender.sv
// Purpose: Bank of value sender channels sharing one network port
// Assumes: Inputs synchronous to i_clk; i_cycle_tick marks a processing cycle
// Notes:   Round-robin service; one network job at a time
`default_nettype none
`include "nvs_map.svh"

module nvs_sender
	import nvs_pkg::*;
#(
	parameter int ACK_TIMEOUT_CYCLES = `NVS_ACK_TIMEOUT_CYC
)(
	input  wire logic                                   i_clk,
	input  wire logic                                   i_rst_n,
	input  wire logic                                   i_ce,
	input  wire logic                                   i_cycle_tick,
	input  wire nvs_cfg_type [`NVS_CHANNELS-1:0]        i_cfg,
	input  wire nvs_in_type  [`NVS_CHANNELS-1:0]        i_chan,
	output nvs_out_type      [`NVS_CHANNELS-1:0]        o_chan,
	input  wire logic                                   i_net_up,
	input  wire logic                                   i_net_ready,
	input  wire logic                                   i_net_ack,
	input  wire logic                                   i_net_nak,
	output logic                                        o_net_valid,
	output logic [`NVS_SRC_W-1:0]                       o_net_src,
	output logic signed [`NVS_VALUE_W-1:0]              o_net_data,
	output logic                                        o_busy,
	output logic [`NVS_CNT_W-1:0]                       o_sent_count,
	output logic [`NVS_CNT_W-1:0]                       o_fail_count
);

	localparam logic [`NVS_TMR_W-1:0] TMR_LAST = `NVS_TMR_W'(ACK_TIMEOUT_CYCLES - 1);

	nvs_state_type                      state;
	logic [`NVS_CHANNELS-1:0]           req;
	logic [`NVS_CHANNELS-1:0]           done_vec;
	logic [`NVS_CHANNELS-1:0]           fail_vec;
	logic signed [`NVS_VALUE_W-1:0]     hold [`NVS_CHANNELS];
	logic [`NVS_SRC_W-1:0]              ptr;
	logic [`NVS_SRC_W-1:0]              pick;
	logic                               found;
	logic [`NVS_TMR_W-1:0]              tmr;
	logic                               finish;
	logic                               finish_fail;

	// One sender per channel
	generate
		for (genvar g = 0; g < `NVS_CHANNELS; g++) begin : g_chan
			nvs_channel u_chan (
				.i_clk        (i_clk),
				.i_rst_n      (i_rst_n),
				.i_ce         (i_ce),
				.i_cycle_tick (i_cycle_tick),
				.i_cfg        (i_cfg[g]),
				.i_in         (i_chan[g]),
				.i_done       (done_vec[g]),
				.i_fail       (fail_vec[g]),
				.o_req        (req[g]),
				.o_hold       (hold[g]),
				.o_out        (o_chan[g])
			);
		end
	endgenerate

	// Round-robin choice after the last served channel
	always_comb begin
		logic [`NVS_SRC_W-1:0] idx;
		idx   = '0;
		pick  = '0;
		found = 1'b0;
		for (int k = 0; k < `NVS_CHANNELS; k++) begin
			idx = ptr + `NVS_SRC_W'(k + 1);
			if (!found && req[idx]) begin
				pick  = idx;
				found = 1'b1;
			end
		end
	end

	// End of the current network job
	always_comb begin
		finish      = 1'b0;
		finish_fail = 1'b0;
		case (state)
			NVS_IDLE: begin
				finish      = found && (done_vec == '0) && !i_net_up;
				finish_fail = 1'b1;
			end
			NVS_OFFER: begin
				finish      = !i_net_up;
				finish_fail = 1'b1;
			end
			NVS_WAIT: begin
				finish      = i_net_ack || i_net_nak || !i_net_up || (tmr == TMR_LAST);
				finish_fail = !i_net_ack;
			end
			default: begin
				finish      = 1'b0;
				finish_fail = 1'b0;
			end
		endcase
	end

	// Network job sequencer
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			state       <= NVS_IDLE;
			ptr         <= '1;
			o_net_valid <= 1'b0;
			o_net_src   <= '0;
			o_net_data  <= `NVS_VALUE_RST;
			tmr         <= '0;
		end else if (i_ce) begin
			case (state)
				NVS_IDLE: begin
					if (found && (done_vec == '0)) begin
						ptr       <= pick;
						o_net_src <= pick;
						if (i_net_up) begin
							o_net_valid <= 1'b1;
							o_net_data  <= hold[pick];
							state       <= NVS_OFFER;
						end
					end
				end
				NVS_OFFER: begin
					if (!i_net_up) begin
						o_net_valid <= 1'b0;
						state       <= NVS_IDLE;
					end else if (i_net_ready) begin
						o_net_valid <= 1'b0;
						tmr         <= '0;
						state       <= NVS_WAIT;
					end
				end
				NVS_WAIT: begin
					if (finish) begin
						state <= NVS_IDLE;
					end else begin
						tmr <= tmr + `NVS_TMR_W'(1);
					end
				end
				default: begin
					o_net_valid <= 1'b0;
					state       <= NVS_IDLE;
				end
			endcase
		end
	end

	// Completion pulses back to the channels
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			done_vec <= '0;
			fail_vec <= '0;
		end else if (i_ce) begin
			done_vec <= '0;
			fail_vec <= '0;
			if (finish) begin
				done_vec[(state == NVS_IDLE) ? pick : o_net_src] <= 1'b1;
				fail_vec[(state == NVS_IDLE) ? pick : o_net_src] <= finish_fail;
			end
		end
	end

	// Job statistics and busy flag
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_sent_count <= `NVS_CNT_RST;
			o_fail_count <= `NVS_CNT_RST;
			o_busy       <= 1'b0;
		end else if (i_ce) begin
			o_busy <= (state != NVS_IDLE) || (req != '0);
			if (finish && finish_fail) begin
				o_fail_count <= o_fail_count + `NVS_CNT_W'(1);
			end else if (finish) begin
				o_sent_count <= o_sent_count + `NVS_CNT_W'(1);
			end
		end
	end

endmodule // nvs_sender

`default_nettype wire

// ### design/nvs_map.svh
// Purpose: Constants of the value sender block
// Assumes: Included by the package and the design modules
// Notes:   Offsets are absent, the block has no register bus
`ifndef NVS_MAP_SVH
`define NVS_MAP_SVH

`define NVS_CHANNELS        32
`define NVS_SRC_W           5
`define NVS_VALUE_W         32
`define NVS_PERIOD_W        16
`define NVS_TMR_W           16
`define NVS_CNT_W           16
`define NVS_VALUE_RST       32'h00000000
`define NVS_CNT_RST         16'h0000
`define NVS_CLK_MHZ         50
`define NVS_ACK_TIMEOUT_US  100
`define NVS_ACK_TIMEOUT_CYC (`NVS_ACK_TIMEOUT_US * `NVS_CLK_MHZ)

`endif

// ### design/nvs_pkg.sv
// Purpose: Types of the value sender block
// Assumes: nvs_map.svh supplies the widths
// Notes:   Channel carriers are packed structs
`default_nettype none
`include "nvs_map.svh"

package nvs_pkg;

	typedef struct packed {
		logic                            cyclic;
		logic                            use_enable;
		logic [`NVS_PERIOD_W-1:0]        period;
	} nvs_cfg_type;

	typedef struct packed {
		logic                            enable;
		logic                            sender_trigger_coil;
		logic signed [`NVS_VALUE_W-1:0]  send_value;
	} nvs_in_type;

	typedef struct packed {
		logic                            trigger_echo;
		logic                            job_active;
		logic                            send_error;
	} nvs_out_type;

	typedef enum logic [1:0] {
		NVS_IDLE,
		NVS_OFFER,
		NVS_WAIT
	} nvs_state_type;

endpackage

`default_nettype wire

// ### design/nvs_channel.sv
// Purpose: One value sender channel
// Assumes: Inputs synchronous to i_clk; i_done and i_fail are one-cycle pulses
// Notes:   Outputs all come from flip-flops
`default_nettype none
`include "nvs_map.svh"

module nvs_channel
	import nvs_pkg::*;
(
	input  wire logic                           i_clk,
	input  wire logic                           i_rst_n,
	input  wire logic                           i_ce,
	input  wire logic                           i_cycle_tick,
	input  wire nvs_cfg_type                    i_cfg,
	input  wire nvs_in_type                     i_in,
	input  wire logic                           i_done,
	input  wire logic                           i_fail,
	output logic                                o_req,
	output logic signed [`NVS_VALUE_W-1:0]      o_hold,
	output nvs_out_type                         o_out
);

	logic                       trig_prev;
	logic [`NVS_PERIOD_W-1:0]   cyc_cnt;
	logic [`NVS_PERIOD_W-1:0]   period_last;
	logic                       run;
	logic                       rise;
	logic                       cyc_due;
	logic                       start;

	assign run         = !i_cfg.use_enable || i_in.enable;
	assign rise        = i_in.sender_trigger_coil && !trig_prev;
	assign period_last = (i_cfg.period == '0) ? '0 : i_cfg.period - `NVS_PERIOD_W'(1);
	assign cyc_due     = i_cycle_tick && (cyc_cnt >= period_last);
	assign start       = run && !o_out.job_active && (i_cfg.cyclic ? cyc_due : rise);

	// Edge memory
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			trig_prev <= 1'b0;
		end else if (i_ce) begin
			trig_prev <= i_in.sender_trigger_coil;
		end
	end

	// Processing cycle counter
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			cyc_cnt <= '0;
		end else if (i_ce) begin
			if (!run || !i_cfg.cyclic) begin
				cyc_cnt <= '0;
			end else if (i_cycle_tick) begin
				cyc_cnt <= cyc_due ? '0 : cyc_cnt + `NVS_PERIOD_W'(1);
			end
		end
	end

	// Echo of the trigger
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_out.trigger_echo <= 1'b0;
		end else if (i_ce) begin
			o_out.trigger_echo <= i_in.sender_trigger_coil;
		end
	end

	// Value capture, full signed width
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_hold <= `NVS_VALUE_RST;
		end else if (i_ce && start) begin
			o_hold <= i_in.send_value;
		end
	end

	// Job state and error flag
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_req             <= 1'b0;
			o_out.job_active  <= 1'b0;
			o_out.send_error  <= 1'b0;
		end else if (i_ce) begin
			if (start) begin
				o_req            <= 1'b1;
				o_out.job_active <= 1'b1;
				o_out.send_error <= 1'b0;
			end else if (i_done) begin
				o_req            <= 1'b0;
				o_out.job_active <= 1'b0;
				o_out.send_error <= i_fail;
			end
		end
	end

endmodule // nvs_channel

`default_nettype wire

// ### sim/nvs_sender_properties.sv
// Purpose: Timing checks on channel 0 and the network port of the sender
// Assumes: Clock enable held high
// Notes:   Bound into nvs_sender
`default_nettype none
`include "nvs_map.svh"

module nvs_sender_properties
	import nvs_pkg::*;
(
	input  wire logic                             i_clk,
	input  wire logic                             i_rst_n,
	input  wire nvs_cfg_type [`NVS_CHANNELS-1:0]  i_cfg,
	input  wire nvs_in_type  [`NVS_CHANNELS-1:0]  i_chan,
	input  wire nvs_out_type [`NVS_CHANNELS-1:0]  o_chan,
	input  wire logic                             i_net_up,
	input  wire logic                             i_net_ready,
	input  wire logic                             o_net_valid,
	input  wire logic [`NVS_SRC_W-1:0]            o_net_src,
	input  wire logic signed [`NVS_VALUE_W-1:0]   o_net_data,
	input  wire logic                             o_busy
);
	wire tr  = i_chan[0].sender_trigger_coil;
	wire ec  = o_chan[0].trigger_echo;
	wire ja  = o_chan[0].job_active;
	wire er  = o_chan[0].send_error;
	wire edg = !i_cfg[0].cyclic && (!i_cfg[0].use_enable || i_chan[0].enable);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	trig_echo_a: assert property ($past(i_rst_n) |-> ec == $past(tr))
		else $error("trigger echo wrong");
	job_start_a: assert property (edg && $rose(tr) && !ja |=> ja && !er)
		else $error("job did not start");
	hold_off_a: assert property (i_cfg[0].use_enable && !i_chan[0].enable && !ja |=> !ja)
		else $error("job started while disabled");
	one_edge_a: assert property (!i_cfg[0].cyclic && $fell(ja) && $past(tr) && tr |=> !ja)
		else $error("job without new edge");
	err_hold_a: assert property (er |=> er || $rose(ja))
		else $error("error cleared early");
	err_rise_a: assert property ($rose(er) |-> $fell(ja))
		else $error("error not at job end");
	word_hold_a: assert property (o_net_valid && !i_net_ready && i_net_up
		|=> o_net_valid && $stable(o_net_data) && $stable(o_net_src))
		else $error("offered word changed");
	busy_seen_a: assert property ($rose(ja) |-> ##[0:2] o_busy)
		else $error("busy missing");
endmodule // nvs_sender_properties

bind nvs_sender nvs_sender_properties nvs_sender_properties_i (.i_clk(i_clk),
	.i_rst_n(i_rst_n), .i_cfg(i_cfg), .i_chan(i_chan), .o_chan(o_chan),
	.i_net_up(i_net_up), .i_net_ready(i_net_ready), .o_net_valid(o_net_valid),
	.o_net_src(o_net_src), .o_net_data(o_net_data), .o_busy(o_busy));
`default_nettype wire

// ### sim/nvs_net_model.sv
// Purpose: Network side that takes offered words
// Assumes: Stall, fail and mute set by the bench
// Notes:   Answers one cycle after handover
`default_nettype none

module nvs_net_model (
	input  wire logic  i_clk,
	input  wire logic  i_valid,
	input  wire logic  i_stall,
	input  wire logic  i_fail,
	input  wire logic  i_mute,
	output logic       o_ready,
	output logic       o_ack,
	output logic       o_nak
);
	assign o_ready = i_valid && !i_stall;
	always_ff @(posedge i_clk) begin
		o_ack <= o_ready && !i_fail && !i_mute;
		o_nak <= o_ready && i_fail && !i_mute;
	end
endmodule // nvs_net_model
`default_nettype wire

// ### sim/nvs_sender_tb.sv
// Purpose: Self-checking bench of the value sender
// Assumes: Clock enable held high
// Notes:   Channels 0 and 31 exercised
`default_nettype none

module nvs_sender_tb
	import nvs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, rst_n = 1'b0, tick = 1'b0, up = 1'b0, stall = 1'b0, fail = 1'b0;
	logic mute = 1'b0;
	nvs_cfg_type [31:0] cfg = '0;
	nvs_in_type  [31:0] chan = '0;
	nvs_out_type [31:0] outs;
	logic               rdy, ack, nak, valid, busy;
	logic [4:0]         src;
	logic signed [31:0] data;
	logic [15:0]        sent, failed;
	int                 error_cnt = 0, checks_done = 0;
	always #10 clk = ~clk;
	nvs_sender #(.ACK_TIMEOUT_CYCLES(20)) nvs_sender_i (.i_clk(clk), .i_rst_n(rst_n),
		.i_ce(1'b1), .i_cycle_tick(tick), .i_cfg(cfg), .i_chan(chan), .o_chan(outs),
		.i_net_up(up), .i_net_ready(rdy), .i_net_ack(ack), .i_net_nak(nak),
		.o_net_valid(valid), .o_net_src(src), .o_net_data(data), .o_busy(busy),
		.o_sent_count(sent), .o_fail_count(failed));
	nvs_net_model nvs_net_model_i (.i_clk(clk), .i_valid(valid), .i_stall(stall),
		.i_fail(fail), .i_mute(mute), .o_ready(rdy), .o_ack(ack), .o_nak(nak));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up;
		$display("errors=%0d checks=%0d", error_cnt, checks_done);
		if (error_cnt == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic wait_ja(input int c, input logic lvl);
		int n;
		n = 0;
		while (outs[c].job_active !== lvl && n < 60) begin
			@(negedge clk);
			n++;
		end
		chk(outs[c].job_active, lvl);
	endtask
	task automatic send(input int c, input logic [31:0] v, input logic f, input logic s);
		int n;
		fail = f;
		stall = s;
		chan[c].send_value = v;
		chan[c].sender_trigger_coil = 1'b1;
		@(negedge clk);
		chk(outs[c].trigger_echo, 1'b1);
		wait_ja(c, 1'b1);
		chk(outs[c].send_error, 1'b0);
		chan[c].send_value = ~v;
		n = 0;
		while (valid !== 1'b1 && n < 40) begin
			@(negedge clk);
			n++;
		end
		chk(valid, 1'b1);
		chk(src, c);
		chk(data, v);
		chk(busy, 1'b1);
		repeat (3) @(negedge clk);
		stall = 1'b0;
		wait_ja(c, 1'b0);
		chk(outs[c].send_error, f);
		repeat (3) @(negedge clk);
		chk(outs[c].job_active, 1'b0);
		chk(busy, 1'b0);
		chan[c].sender_trigger_coil = 1'b0;
		@(negedge clk);
	endtask
	task automatic t_values;
		send(0, 32'h80000000, 1'b0, 1'b1);
		send(0, 32'h7FFFFFFF, 1'b0, 1'b0);
		send(31, 32'hFFFFFFFF, 1'b0, 1'b0);
	endtask
	task automatic t_error;
		logic [15:0] base;
		base = failed;
		send(0, 32'h12345678, 1'b1, 1'b0);
		repeat (5) @(negedge clk);
		chk(outs[0].send_error, 1'b1);
		send(0, 32'h00000001, 1'b0, 1'b0);
		mute = 1'b1;
		send(0, 32'h00000002, 1'b1, 1'b0);
		mute = 1'b0;
		up = 1'b0;
		chan[0].sender_trigger_coil = 1'b1;
		wait_ja(0, 1'b1);
		wait_ja(0, 1'b0);
		chk(outs[0].send_error, 1'b1);
		chk(valid, 1'b0);
		chk(failed - base, 32'h00000003);
		chan[0].sender_trigger_coil = 1'b0;
		up = 1'b1;
		@(negedge clk);
	endtask
	task automatic t_enable;
		chan[0].enable = 1'b0;
		chan[0].sender_trigger_coil = 1'b1;
		repeat (5) @(negedge clk);
		chk(outs[0].job_active, 1'b0);
		chan[0].sender_trigger_coil = 1'b0;
		cfg[0].use_enable = 1'b0;
		@(negedge clk);
		send(0, 32'h0000ABCD, 1'b0, 1'b0);
		cfg[0].use_enable = 1'b1;
		chan[0].enable = 1'b1;
	endtask
	task automatic t_cyclic;
		logic [15:0] base;
		base = sent;
		cfg[0].cyclic = 1'b1;
		cfg[0].period = 16'h0003;
		repeat (6) begin
			tick = 1'b1;
			@(negedge clk);
			tick = 1'b0;
			repeat (8) @(negedge clk);
		end
		chk(sent - base, 32'h00000002);
		cfg[0].cyclic = 1'b0;
	endtask
	initial begin
		cfg[0].use_enable = 1'b1;
		chan[0].enable = 1'b1;
		repeat (8) @(negedge clk);
		rst_n = 1'b1;
		up = 1'b1;
		t_values;
		t_error;
		t_enable;
		t_cyclic;
		wrap_up;
	end
	initial begin
		#100000;
		error_cnt++;
		wrap_up;
	end
endmodule // nvs_sender_tb
`default_nettype wire
